// file: dv/tb.sv
`include "ets_regs.svh"

module tb
   import ets_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // ----------------------------------------------------------------------
   // Design ports.
   // ----------------------------------------------------------------------
   logic        clk;
   logic        rst_n;
   logic [1:0]  ev;
   logic [29:0] t_ns;
   logic [31:0] t_sec;
   logic [2:0]  t_slot;
   logic [15:0] awaddr;
   logic        awvalid;
   logic        awready;
   logic [31:0] wdata;
   logic [3:0]  wstrb;
   logic        wvalid;
   logic        wready;
   logic [1:0]  bresp;
   logic        bvalid;
   logic        bready;
   logic [15:0] araddr;
   logic        arvalid;
   logic        arready;
   logic [31:0] rdata;
   logic [1:0]  rresp;
   logic        rvalid;
   logic        rready;
   int          errors;
   int          comparisons;
   logic [31:0] rd;
   logic [1:0]  rsp;
   logic [31:0] ns_exp;
   logic [2:0]  slot_tab [7] = '{3'h3, 3'h1, 3'h4, 3'h4, 3'h2, 3'h1, 3'h0};
   localparam int LIMIT = 200;

   ets_sample_readout #(.UNITS(2), .ADDR_W(16)) ets_sample_readout_i (
      .CLK_SYS_I(clk), .RESETN_I(rst_n), .EVENT_I(ev),
      .TIME_NS_I(t_ns), .TIME_SEC_I(t_sec), .TIME_SLOT_I(t_slot),
      .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
      .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid),
      .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
      .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
      .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
      .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready)
   );

   // Clock of 4 ns period.
   always #2 clk = ~clk;

   // ----------------------------------------------------------------------
   // Shared tasks.
   // ----------------------------------------------------------------------
   // Prints the verdict and ends the run.
   task automatic summarize();
      if (errors == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : summarize

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // A bound that runs out is counted and closes the run.
   task automatic timed_out(input int n);
      if (n >= LIMIT) begin
         errors++;
         $display("[ERR] %0t bus handshake never completed", $time);
         summarize();
      end
   endtask : timed_out

   // Address and data are offered together and released one by one as taken.
   task automatic axi_write(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
                            output logic [1:0] resp);
      int   n;
      logic aw_done;
      logic w_done;
      n = 0;
      aw_done = 1'b0;
      w_done = 1'b0;
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wstrb <= s;
      wvalid <= 1'b1;
      while (!(aw_done && w_done) && n < LIMIT) begin
         @(posedge clk);
         n++;
         if (!aw_done && awready) begin
            aw_done = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_done && wready) begin
            w_done = 1'b1;
            wvalid <= 1'b0;
         end
      end
      timed_out(n);
      // Ready for the answer only once both halves are taken.
      bready <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (!bvalid && n < LIMIT);
      timed_out(n);
      resp = bresp;
      bready <= 1'b0;
   endtask : axi_write

   task automatic axi_read(input logic [15:0] a, output logic [31:0] d,
                           output logic [1:0] resp);
      int n;
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (!arready && n < LIMIT);
      timed_out(n);
      arvalid <= 1'b0;
      // Raised after the address edge so back-to-back reads never drive it twice at once.
      rready <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (!rvalid && n < LIMIT);
      timed_out(n);
      d = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask : axi_read

   // Reads one word and compares both the data and the response code.
   task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp, input logic [1:0] er);
      axi_read(a, rd, rsp);
      check(rd, exp);
      check({30'h0, rsp}, {30'h0, er});
   endtask : rd_chk

   // Time is held steady well around the edge so the stamp is unambiguous.
   task automatic fire(input int u, input logic lvl, input logic [29:0] ns,
                       input logic [31:0] sec, input logic [2:0] sl);
      t_ns <= ns;
      t_sec <= sec;
      t_slot <= sl;
      @(posedge clk);
      ev[u] <= lvl;
      repeat (12) @(posedge clk);
   endtask : fire

   // ----------------------------------------------------------------------
   // Main sequence.
   // ----------------------------------------------------------------------
   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      ev = 2'b00;
      t_ns = 30'h0;
      t_sec = 32'h0;
      t_slot = 3'h0;
      awaddr = 16'h0;
      awvalid = 1'b0;
      wdata = 32'h0;
      wstrb = 4'h0;
      wvalid = 1'b0;
      bready = 1'b0;
      araddr = 16'h0;
      arvalid = 1'b0;
      rready = 1'b0;
      errors = 0;
      comparisons = 0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      // reset values of every sample word.
      rd_chk(`ETS_OFF_S5_SEC, 32'h0000_0000, ETS_RESP_OKAY);
      rd_chk(`ETS_OFF_S5_PHASE, 32'h0000_0000, ETS_RESP_OKAY);
      rd_chk(`ETS_OFF_S6_NANOS, 32'h0000_0000, ETS_RESP_OKAY);
      rd_chk(`ETS_OFF_S6_SEC, 32'h0000_0000, ETS_RESP_OKAY);
      rd_chk(`ETS_OFF_S6_PHASE, 32'h0000_0000, ETS_RESP_OKAY);
      rd_chk(`ETS_OFF_S7_NANOS, 32'h0000_0000, ETS_RESP_OKAY);
      rd_chk(`ETS_OFF_CTRL, 32'h0000_0001, ETS_RESP_OKAY);
      // software writes leave sample words untouched.
      axi_write(`ETS_OFF_S5_SEC, 32'hFFFF_FFFF, 4'hF, rsp);
      check({30'h0, rsp}, {30'h0, ETS_RESP_OKAY});
      rd_chk(`ETS_OFF_S5_SEC, 32'h0000_0000, ETS_RESP_OKAY);
      // Unmapped places answer with an error and zero data.
      rd_chk(16'h0584, 32'h0000_0000, ETS_RESP_SLVERR);
      axi_write(16'h05A0, 32'h1234_5678, 4'hF, rsp);
      check({30'h0, rsp}, {30'h0, ETS_RESP_SLVERR});
      // seven alternating edges on unit 0 rotate through the slots.
      for (int i = 0; i < 7; i++) begin
         fire(0, ~ev[0], 30'(32'h0ABC_0000 + i), 32'h5000_0000 + i, slot_tab[i]);
         case (i % 3)
            0: begin
               rd_chk(`ETS_OFF_S5_SEC, 32'h5000_0000 + i, ETS_RESP_OKAY);
               rd_chk(`ETS_OFF_S5_PHASE, {29'h0, slot_tab[i]}, ETS_RESP_OKAY);
            end
            1: begin
               ns_exp = {1'b0, ev[0], 30'(32'h0ABC_0000 + i)};
               rd_chk(`ETS_OFF_S6_NANOS, ns_exp, ETS_RESP_OKAY);
               rd_chk(`ETS_OFF_S6_SEC, 32'h5000_0000 + i, ETS_RESP_OKAY);
               rd_chk(`ETS_OFF_S6_PHASE, {29'h0, slot_tab[i]}, ETS_RESP_OKAY);
            end
            default: begin
               ns_exp = {1'b0, ev[0], 30'(32'h0ABC_0000 + i)};
               rd_chk(`ETS_OFF_S7_NANOS, ns_exp, ETS_RESP_OKAY);
            end
         endcase
      end
      // unit 1 captures without disturbing the bank on view.
      fire(1, 1'b1, 30'h0001_2345, 32'h7777_0001, 3'h2);
      rd_chk(`ETS_OFF_S5_SEC, 32'h5000_0006, ETS_RESP_OKAY);
      rd_chk(`ETS_OFF_STATUS, 32'h0000_0011, ETS_RESP_OKAY);
      // index bit selects the second bank.
      axi_write(`ETS_OFF_CTRL, 32'h0000_0101, 4'h3, rsp);
      check({30'h0, rsp}, {30'h0, ETS_RESP_OKAY});
      rd_chk(`ETS_OFF_S5_SEC, 32'h7777_0001, ETS_RESP_OKAY);
      rd_chk(`ETS_OFF_S5_PHASE, 32'h0000_0002, ETS_RESP_OKAY);
      rd_chk(`ETS_OFF_S6_SEC, 32'h0000_0000, ETS_RESP_OKAY);
      // Lane 1 disabled keeps the index while capture is switched off.
      axi_write(`ETS_OFF_CTRL, 32'h0000_0000, 4'h1, rsp);
      rd_chk(`ETS_OFF_CTRL, 32'h0000_0100, ETS_RESP_OKAY);
      fire(1, 1'b0, 30'h0002_0000, 32'h7777_0002, 3'h1);
      rd_chk(`ETS_OFF_S6_SEC, 32'h0000_0000, ETS_RESP_OKAY);
      rd_chk(`ETS_OFF_STATUS, 32'h0000_0011, ETS_RESP_OKAY);
      // Back to bank 0, whose words must still hold their captures.
      axi_write(`ETS_OFF_CTRL, 32'h0000_0001, 4'h3, rsp);
      rd_chk(`ETS_OFF_S7_NANOS, 32'h0ABC_0005, ETS_RESP_OKAY);
      summarize();
   end
endmodule : tb

// file: src/ets_edge_sync.sv
module ets_edge_sync (
   // Clock and reset.
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   // Asynchronous event pin.
   input  wire logic pin_i,
   // Qualified transition.
   output logic      pulse_o,
   output logic      rising_o
);

   logic s1_reg;
   logic s2_reg;
   logic s3_reg;
   logic stable_reg;

   // Three-stage synchroniser; only the second stage reads the first.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
      end else begin
         s1_reg <= pin_i;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // A change counts once stages two and three agree, filtering one-cycle glitches.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         stable_reg <= 1'b0;
         pulse_o    <= 1'b0;
         rising_o   <= 1'b0;
      end else begin
         pulse_o <= 1'b0;
         if (s2_reg == s3_reg && s3_reg != stable_reg) begin
            stable_reg <= s3_reg;
            pulse_o    <= 1'b1;
            rising_o   <= s3_reg;
         end
      end
   end

endmodule : ets_edge_sync

// file: src/ets_pkg.sv
package ets_pkg;

   // ----------------------------------------------------------------------
   // Sample fields.
   // ----------------------------------------------------------------------
   typedef logic [29:0] ets_nanos_t;
   typedef logic [31:0] ets_secs_t;
   typedef logic [2:0]  ets_phase_t;

   // One captured event time, loaded as a whole.
   typedef struct packed {
      logic       rising;
      ets_nanos_t nanos;
      ets_secs_t  secs;
      ets_phase_t phase;
   } ets_sample_t;

   // AXI response codes.
   typedef enum logic [1:0] {
      ETS_RESP_OKAY   = 2'b00,
      ETS_RESP_SLVERR = 2'b10
   } ets_resp_t;

   // Maps the slot number 0..4 inside the reference period to its phase code.
   function automatic ets_phase_t ets_slot_code(input logic [2:0] slot);
      ets_phase_t code;
      code = 3'h0;
      unique case (slot)
         3'h0: code = 3'h0;
         3'h1: code = 3'h1;
         3'h2: code = 3'h2; // Printed 16 ns code collides with reserved.
         3'h3: code = 3'h3;
         3'h4: code = 3'h4;
         default: code = 3'h0;
      endcase
      return code;
   endfunction : ets_slot_code

endpackage : ets_pkg

// file: src/ets_regs.svh
`ifndef ETS_REGS_SVH
`define ETS_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses).
// ----------------------------------------------------------------------
`define ETS_OFF_S5_SEC   16'h0588
`define ETS_OFF_S5_PHASE 16'h058C
`define ETS_OFF_S6_NANOS 16'h0590
`define ETS_OFF_S6_SEC   16'h0594
`define ETS_OFF_S6_PHASE 16'h0598
`define ETS_OFF_S7_NANOS 16'h059C
`define ETS_OFF_CTRL     16'h0600
`define ETS_OFF_STATUS   16'h0604

// ----------------------------------------------------------------------
// Field positions and reset values.
// ----------------------------------------------------------------------
`define ETS_POS_POLARITY 30
`define ETS_POS_UNIT_IDX 8
`define ETS_POS_CAP_EN   0
`define ETS_RST_SAMPLE   32'h0000_0000
`define ETS_RST_CAP_EN   1'b1
`define ETS_RST_UNIT_IDX 1'b0

// ----------------------------------------------------------------------
// Timing: reference period and slot width in ns.
// ----------------------------------------------------------------------
`define ETS_REF_PERIOD_NS 40
`define ETS_SLOT_NS       8
`define ETS_SLOTS_PER_REF (`ETS_REF_PERIOD_NS / `ETS_SLOT_NS)

`endif

// file: src/ets_sample_readout.sv
// Contract
// - Unit index bit 8 selects presented bank.
// - Nanoseconds bit 30 gives capture polarity.
// - Nanoseconds bits 29:0 hold captured nanoseconds.
// - Seconds registers are 32-bit read-only, reset zero.
// - Phase bits 2:0 encode the sub-8ns slot.
// - Five 8 ns slots per 40 ns period.
// - Read-only fields reset zero; reserved bits zero.
`include "ets_regs.svh"

module ets_sample_readout
   import ets_pkg::*;
#(
   parameter int UNITS  = 2,
   parameter int ADDR_W = 16
) (
   // Clock and reset.
   input  wire logic              CLK_SYS_I,
   input  wire logic              RESETN_I,
   // Event pins, one per timestamp unit.
   input  wire logic [UNITS-1:0]  EVENT_I,
   // Running time from the local clock, same domain.
   input  wire logic [29:0]       TIME_NS_I,
   input  wire logic [31:0]       TIME_SEC_I,
   input  wire logic [2:0]        TIME_SLOT_I,
   // AXI4-Lite write address and data.
   input  wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
   input  wire logic              S_AXI_AWVALID_I,
   output logic                   S_AXI_AWREADY_O,
   input  wire logic [31:0]       S_AXI_WDATA_I,
   input  wire logic [3:0]        S_AXI_WSTRB_I,
   input  wire logic              S_AXI_WVALID_I,
   output logic                   S_AXI_WREADY_O,
   // AXI4-Lite write response.
   output logic [1:0]             S_AXI_BRESP_O,
   output logic                   S_AXI_BVALID_O,
   input  wire logic              S_AXI_BREADY_I,
   // AXI4-Lite read.
   input  wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
   input  wire logic              S_AXI_ARVALID_I,
   output logic                   S_AXI_ARREADY_O,
   output logic [31:0]            S_AXI_RDATA_O,
   output logic [1:0]             S_AXI_RRESP_O,
   output logic                   S_AXI_RVALID_O,
   input  wire logic              S_AXI_RREADY_I
);

   // ----------------------------------------------------------------------
   // Elaboration checks.
   // ----------------------------------------------------------------------
   // The index pointer is a single bit, so at most two units can be served.
   if (UNITS < 1 || UNITS > 2) begin : g_bad_units
      $error("UNITS must be 1 or 2");
   end
   if (ADDR_W < 12) begin : g_bad_addr
      $error("ADDR_W too narrow for the register map");
   end
   // The phase code table serves exactly five slots per reference period.
   if (`ETS_SLOTS_PER_REF != 5) begin : g_bad_slots
      $error("slot table expects five slots per period");
   end

   localparam int SLOTS = 3;

   // ----------------------------------------------------------------------
   // Declarations.
   // ----------------------------------------------------------------------
   ets_sample_t       samples_reg [UNITS][SLOTS];
   logic [1:0]        wr_ptr_reg  [UNITS];
   logic [UNITS-1:0]  evt_pulse;
   logic [UNITS-1:0]  evt_rising;
   logic              cap_en_reg;
   logic              unit_idx_reg;
   logic              sel_u;
   logic              aw_held_reg;
   logic              w_held_reg;
   logic [ADDR_W-1:0] aw_addr_reg;
   logic [31:0]       w_data_reg;
   logic [3:0]        w_strb_reg;
   logic [ADDR_W-1:0] rd_addr_reg;
   logic [31:0]       rd_next;
   logic              rd_hit;
   logic              wr_do;
   logic              wr_hit;
   ets_phase_t        slot_code;

   // Bank actually shown; a single-unit build always shows bank zero.
   assign sel_u     = (UNITS > 1) ? unit_idx_reg : 1'b0;
   assign slot_code = ets_slot_code(TIME_SLOT_I);

   // ----------------------------------------------------------------------
   // Event input qualification.
   // ----------------------------------------------------------------------
   for (genvar u = 0; u < UNITS; u++) begin : g_sync
      ets_edge_sync u_sync (
         .clk_i    (CLK_SYS_I),
         .rst_n_i  (RESETN_I),
         .pin_i    (EVENT_I[u]),
         .pulse_o  (evt_pulse[u]),
         .rising_o (evt_rising[u])
      );
   end

   // ----------------------------------------------------------------------
   // Capture storage.
   // ----------------------------------------------------------------------
   // While capture is enabled, each qualified transition fills the next of the three slots in turn.
   // The stamp lags the pin by the three synchroniser stages plus the agreement check
   // and the pulse register, a fixed offset that software may subtract.
   always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         for (int u = 0; u < UNITS; u++) begin
            wr_ptr_reg[u] <= 2'h0;
            for (int s = 0; s < SLOTS; s++) begin
               samples_reg[u][s] <= '0;
            end
         end
      end else begin
         for (int u = 0; u < UNITS; u++) begin
            if (cap_en_reg && evt_pulse[u]) begin
               samples_reg[u][wr_ptr_reg[u]] <= '{
                  rising: evt_rising[u],
                  nanos:  TIME_NS_I,
                  secs:   TIME_SEC_I,
                  phase:  slot_code
               };
               wr_ptr_reg[u] <= (wr_ptr_reg[u] == 2'h2) ? 2'h0 : wr_ptr_reg[u] + 2'h1;
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // Write channel.
   // ----------------------------------------------------------------------
   assign wr_do  = aw_held_reg && w_held_reg && !S_AXI_BVALID_O;
   assign wr_hit = (aw_addr_reg == `ETS_OFF_CTRL);

   // Address and data are taken in either order and held until both exist.
   always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         S_AXI_AWREADY_O <= 1'b1;
         aw_held_reg     <= 1'b0;
         aw_addr_reg     <= '0;
      end else begin
         if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
            S_AXI_AWREADY_O <= 1'b0;
            aw_held_reg     <= 1'b1;
            aw_addr_reg     <= S_AXI_AWADDR_I;
         end else if (wr_do) begin
            aw_held_reg <= 1'b0;
         end else if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
            S_AXI_AWREADY_O <= 1'b1;
         end
      end
   end

   always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         S_AXI_WREADY_O <= 1'b1;
         w_held_reg     <= 1'b0;
         w_data_reg     <= 32'h0000_0000;
         w_strb_reg     <= 4'h0;
      end else begin
         if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
            S_AXI_WREADY_O <= 1'b0;
            w_held_reg     <= 1'b1;
            w_data_reg     <= S_AXI_WDATA_I;
            w_strb_reg     <= S_AXI_WSTRB_I;
         end else if (wr_do) begin
            w_held_reg <= 1'b0;
         end else if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
            S_AXI_WREADY_O <= 1'b1;
         end
      end
   end

   // Response: writes to the sample registers are ignored but acknowledged.
   always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         S_AXI_BVALID_O <= 1'b0;
         S_AXI_BRESP_O  <= ETS_RESP_OKAY;
      end else begin
         if (wr_do) begin
            S_AXI_BVALID_O <= 1'b1;
            S_AXI_BRESP_O  <= (wr_hit || rd_map(aw_addr_reg)) ? ETS_RESP_OKAY
                                                               : ETS_RESP_SLVERR;
         end else if (S_AXI_BREADY_I) begin
            S_AXI_BVALID_O <= 1'b0;
         end
      end
   end

   // Control register, byte lanes honoured.
   always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         cap_en_reg   <= `ETS_RST_CAP_EN;
         unit_idx_reg <= `ETS_RST_UNIT_IDX;
      end else if (wr_do && wr_hit) begin
         if (w_strb_reg[0]) begin
            cap_en_reg <= w_data_reg[`ETS_POS_CAP_EN];
         end
         if (w_strb_reg[1]) begin
            unit_idx_reg <= w_data_reg[`ETS_POS_UNIT_IDX];
         end
      end
   end

   // ----------------------------------------------------------------------
   // Read channel.
   // ----------------------------------------------------------------------
   // True for every offset that answers OKAY.
   function automatic logic rd_map(input logic [ADDR_W-1:0] a);
      return a == `ETS_OFF_S5_SEC   || a == `ETS_OFF_S5_PHASE ||
             a == `ETS_OFF_S6_NANOS || a == `ETS_OFF_S6_SEC   ||
             a == `ETS_OFF_S6_PHASE || a == `ETS_OFF_S7_NANOS ||
             a == `ETS_OFF_CTRL     || a == `ETS_OFF_STATUS;
   endfunction : rd_map

   // Formats a nanoseconds word with bit 31 held at zero.
   function automatic logic [31:0] ns_word(input ets_sample_t s);
      return {1'b0, s.rising, s.nanos};
   endfunction : ns_word

   always_comb begin
      rd_next = 32'h0000_0000;
      rd_hit  = rd_map(S_AXI_ARADDR_I);
      unique case (S_AXI_ARADDR_I)
         `ETS_OFF_S5_SEC:   rd_next = samples_reg[sel_u][0].secs;
         `ETS_OFF_S5_PHASE: rd_next = {29'h0, samples_reg[sel_u][0].phase};
         `ETS_OFF_S6_NANOS: rd_next = ns_word(samples_reg[sel_u][1]);
         `ETS_OFF_S6_SEC:   rd_next = samples_reg[sel_u][1].secs;
         `ETS_OFF_S6_PHASE: rd_next = {29'h0, samples_reg[sel_u][1].phase};
         `ETS_OFF_S7_NANOS: rd_next = ns_word(samples_reg[sel_u][2]);
         `ETS_OFF_CTRL: begin
            rd_next[`ETS_POS_CAP_EN]   = cap_en_reg;
            rd_next[`ETS_POS_UNIT_IDX] = unit_idx_reg;
         end
         `ETS_OFF_STATUS: begin
            rd_next[1:0] = wr_ptr_reg[0];
            rd_next[5:4] = wr_ptr_reg[UNITS-1];
         end
         default: rd_next = 32'h0000_0000;
      endcase
   end

   // One read at a time; data is frozen in the register until taken.
   always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         S_AXI_ARREADY_O <= 1'b1;
         S_AXI_RVALID_O  <= 1'b0;
         S_AXI_RDATA_O   <= `ETS_RST_SAMPLE;
         S_AXI_RRESP_O   <= ETS_RESP_OKAY;
         rd_addr_reg     <= '0;
      end else begin
         if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
            S_AXI_ARREADY_O <= 1'b0;
            S_AXI_RVALID_O  <= 1'b1;
            S_AXI_RDATA_O   <= rd_next;
            S_AXI_RRESP_O   <= rd_hit ? ETS_RESP_OKAY : ETS_RESP_SLVERR;
            rd_addr_reg     <= S_AXI_ARADDR_I;
         end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
            S_AXI_ARREADY_O <= 1'b1;
            S_AXI_RVALID_O  <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Assertions.
   // ----------------------------------------------------------------------
   default clocking cb @(posedge CLK_SYS_I);
   endclocking
   default disable iff (!RESETN_I);

   sequence ar_take_s;
      S_AXI_ARVALID_I && S_AXI_ARREADY_O;
   endsequence

   sequence cap0_s;
      cap_en_reg && evt_pulse[0];
   endsequence

   sel_bank_a: assert property (ar_take_s ##0 (S_AXI_ARADDR_I == `ETS_OFF_S6_SEC)
      |=> S_AXI_RDATA_O == $past(samples_reg[sel_u][1].secs))
      else $error("read did not follow unit index");

   edge_pol_a: assert property (cap0_s ##0 (wr_ptr_reg[0] == 2'h1)
      |=> samples_reg[0][1].rising == $past(evt_rising[0]))
      else $error("edge polarity not captured");

   ns_field_a: assert property (ar_take_s ##0 (S_AXI_ARADDR_I == `ETS_OFF_S7_NANOS)
      |=> S_AXI_RDATA_O[29:0] == $past(samples_reg[sel_u][2].nanos))
      else $error("nanoseconds field misplaced");

   sec_load_a: assert property (cap0_s ##0 (wr_ptr_reg[0] == 2'h0)
      |=> samples_reg[0][0].secs == $past(TIME_SEC_I))
      else $error("seconds not captured");

   phase_code_a: assert property ((TIME_SLOT_I == 3'h3) ##0 cap0_s
      |=> samples_reg[0][$past(wr_ptr_reg[0])].phase == 3'h3)
      else $error("phase code wrong for 24 ns slot");

   slot_range_a: assert property (S_AXI_RVALID_O && (rd_addr_reg == `ETS_OFF_S5_PHASE)
      |-> S_AXI_RDATA_O[2:0] < 3'h5)
      else $error("phase outside five slots");

   rsvd_zero_a: assert property (S_AXI_RVALID_O && (rd_addr_reg == `ETS_OFF_S6_PHASE ||
      rd_addr_reg == `ETS_OFF_S6_NANOS) |-> S_AXI_RDATA_O[31] == 1'b0 &&
      (rd_addr_reg != `ETS_OFF_S6_PHASE || S_AXI_RDATA_O[31:3] == 29'h0))
      else $error("reserved bits not zero");

   coherent_a: assert property (cap0_s ##0 (wr_ptr_reg[0] == 2'h2)
      |=> samples_reg[0][2].nanos == $past(TIME_NS_I) &&
          samples_reg[0][2].secs == $past(TIME_SEC_I) &&
          samples_reg[0][2].phase == $past(slot_code))
      else $error("sample fields not loaded together");

   // Read answer timing.
   read_resp_a: assert property (ar_take_s |=> S_AXI_RVALID_O && !S_AXI_ARREADY_O)
      else $error("read answer not one cycle after address");

   // Write answer timing.
   write_resp_a: assert property (aw_held_reg && w_held_reg && !S_AXI_BVALID_O
      |=> S_AXI_BVALID_O && !S_AXI_AWREADY_O && !S_AXI_WREADY_O)
      else $error("write answer not one cycle after both halves");

endmodule : ets_sample_readout
